// *** hw/twscl_latches.sv ***
// twscl_latches: four-way latch bank, double buffering, reference and
// feedback counters, monitor mux and power control.
// assumes one clock; serial pins, ticks and chip enable synchronous to it.
`timescale 1ns/10ps

module twscl_latches
    import twscl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic load_strobe_i,
    input wire logic chip_enable_i,
    input wire logic ref_tick_i,
    input wire logic rf_tick_i,
    output logic monitor_output_o,
    output logic monitor_output_oe_o,
    output logic pump_three_state_o,
    output logic power_down_o,
    output logic [11:0] int_value_o,
    output logic [11:0] frac_value_o,
    output logic [11:0] fraction_modulus_o,
    output logic [11:0] phase_value_o,
    output logic [4:0] ref_count_o,
    output logic ref_doubler_o,
    output logic reference_halving_bit_o,
    output logic [3:0] pump_current_o,
    output logic [1:0] noise_mode_o,
    output logic cycle_slip_reduction_o,
    output logic prescaler_o,
    output logic pd_polarity_o,
    output logic lock_detect_precision_o,
    output logic [6:0] ref_div_total_o,
    output logic ref_pulse_o,
    output logic fb_pulse_o
);

    twscl_serial_if ser ();

    twscl_shifter u_shifter (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .serial_clk_i(serial_clk_i),
        .serial_data_i(serial_data_i),
        .load_strobe_i(load_strobe_i),
        .ser(ser.shifter)
    );

    ////////////////////////////////////////////////////////////////////////
    // write decode
    logic [SEL_W-1:0] sel;
    logic wr0, wr1, wr2, wr3;
    assign sel = ser.word[SEL_W-1:0];
    // 100 is taken but has no fields here; 101..111 match nothing
    assign wr0 = ser.load && sel == TWSCL_SEL_INT_FRAC;
    assign wr1 = ser.load && sel == TWSCL_SEL_PHASE;
    assign wr2 = ser.load && sel == TWSCL_SEL_MOD_REF;
    assign wr3 = ser.load && sel == TWSCL_SEL_FUNC;

    // latch zero: immediate
    logic [3:0] mon_sel_ff;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            int_value_o <= INT_RST;
            frac_value_o <= 12'h000;
            mon_sel_ff <= MON_TRISTATE;
        end else if (wr0) begin
            int_value_o <= ser.word[INT_MSB:INT_LSB];
            frac_value_o <= ser.word[FRAC_MSB:FRAC_LSB];
            mon_sel_ff <= ser.word[MON_MSB:MON_LSB];
        end
    end

    // pending copies of the double-buffered settings
    logic [11:0] pend_phase_ff, pend_mod_ff;
    logic [4:0] pend_r_ff;
    logic pend_dbl_ff, pend_half_ff;
    logic [3:0] pend_cur_ff;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pend_phase_ff <= 12'h000;
            pend_mod_ff <= MOD_RST;
            pend_r_ff <= RCNT_RST;
            pend_dbl_ff <= 1'b0;
            pend_half_ff <= 1'b0;
            pend_cur_ff <= 4'h0;
        end else begin
            if (wr1) begin
                pend_phase_ff <= ser.word[PHASE_MSB:PHASE_LSB];
            end
            if (wr2) begin
                pend_mod_ff <= ser.word[MOD_MSB:MOD_LSB];
                pend_r_ff <= ser.word[RCNT_MSB:RCNT_LSB];
                pend_dbl_ff <= ser.word[DBL_BIT];
                pend_half_ff <= ser.word[HALF_BIT];
                pend_cur_ff <= ser.word[CUR_MSB:CUR_LSB];
            end
        end
    end

    // active copies move only on a latch-zero write
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            phase_value_o <= 12'h000;
            fraction_modulus_o <= MOD_RST;
            ref_count_o <= RCNT_RST;
            ref_doubler_o <= 1'b0;
            reference_halving_bit_o <= 1'b0;
            pump_current_o <= 4'h0;
        end else if (wr0) begin
            phase_value_o <= pend_phase_ff;
            fraction_modulus_o <= pend_mod_ff;
            ref_count_o <= pend_r_ff;
            ref_doubler_o <= pend_dbl_ff;
            reference_halving_bit_o <= pend_half_ff;
            pump_current_o <= pend_cur_ff;
        end
    end

    // single-buffered parts of latches two and three
    logic sd_rst_ff, cp3s_ff, pwrdn_ff, cnt_rst_ff;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            noise_mode_o <= 2'h0;
            cycle_slip_reduction_o <= 1'b0;
            prescaler_o <= 1'b0;
        end else if (wr2) begin
            noise_mode_o <= ser.word[NOISE_MSB:NOISE_LSB];
            cycle_slip_reduction_o <= ser.word[CSR_BIT];
            prescaler_o <= ser.word[PRESC_BIT];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sd_rst_ff <= 1'b0;
            lock_detect_precision_o <= 1'b0;
            pd_polarity_o <= 1'b0;
            pwrdn_ff <= 1'b0;
            cp3s_ff <= 1'b0;
            cnt_rst_ff <= 1'b0;
        end else if (wr3) begin
            sd_rst_ff <= ser.word[SDRST_BIT];
            lock_detect_precision_o <= ser.word[LDP_BIT];
            pd_polarity_o <= ser.word[PDPOL_BIT];
            pwrdn_ff <= ser.word[PWRDN_BIT];
            cp3s_ff <= ser.word[CP3S_BIT];
            cnt_rst_ff <= ser.word[CNTRST_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power control; latches keep their contents while powered down, counters are cleared
    logic halt;
    assign halt = !chip_enable_i || pwrdn_ff || cnt_rst_ff;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            power_down_o <= 1'b1;
            pump_three_state_o <= 1'b1;
        end else begin
            power_down_o <= !chip_enable_i || pwrdn_ff;
            pump_three_state_o <= !chip_enable_i || pwrdn_ff || cp3s_ff;
        end
    end

    // reference ratio r times (1+T); code 0 means 32
    logic [5:0] r_ratio;
    assign r_ratio = (ref_count_o == 5'h00) ? 6'h20 : {1'b0, ref_count_o};
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ref_div_total_o <= 7'h01;
        end else begin
            ref_div_total_o <= reference_halving_bit_o ? {r_ratio, 1'b0}
                                                       : {1'b0, r_ratio};
        end
    end

    // reference counter: 5 bits wrap gives ratio 32 for code 0
    logic [4:0] r_cnt_ff;
    logic half_ph_ff;
    logic r_term;
    assign r_term = 5'(r_cnt_ff + 5'h01) == ref_count_o;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || halt) begin
            r_cnt_ff <= 5'h00;
            half_ph_ff <= 1'b0;
            ref_pulse_o <= 1'b0;
        end else begin
            ref_pulse_o <= 1'b0;
            if (ref_tick_i) begin
                r_cnt_ff <= r_term ? 5'h00 : 5'(r_cnt_ff + 5'h01);
                if (r_term) begin
                    half_ph_ff <= !half_ph_ff;
                    ref_pulse_o <= !reference_halving_bit_o || half_ph_ff;
                end
            end
        end
    end

    // feedback: int counter stretched by one on fraction carry
    // first-order accumulator only; noise shaping lives in the analog side
    logic [11:0] n_cnt_ff, acc_ff;
    logic carry_ff;
    logic [12:0] acc_sum;
    logic [12:0] n_target;
    assign acc_sum = {1'b0, acc_ff} + {1'b0, frac_value_o};
    assign n_target = {1'b0, int_value_o} + {12'h000, carry_ff};
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || halt) begin
            n_cnt_ff <= 12'h000;
            fb_pulse_o <= 1'b0;
        end else begin
            fb_pulse_o <= 1'b0;
            if (rf_tick_i) begin
                if ({1'b0, n_cnt_ff} + 13'h0001 >= n_target) begin
                    n_cnt_ff <= 12'h000;
                    fb_pulse_o <= 1'b1;
                end else begin
                    n_cnt_ff <= 12'(n_cnt_ff + 12'h001);
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || halt || sd_rst_ff) begin
            acc_ff <= 12'h000;
            carry_ff <= 1'b0;
        end else if (rf_tick_i && {1'b0, n_cnt_ff} + 13'h0001 >= n_target) begin
            if (acc_sum >= {1'b0, fraction_modulus_o}) begin
                acc_ff <= 12'(acc_sum - {1'b0, fraction_modulus_o});
                carry_ff <= 1'b1;
            end else begin
                acc_ff <= acc_sum[11:0];
                carry_ff <= 1'b0;
            end
        end
    end

    // monitor mux, registered so the pin never glitches
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            monitor_output_o <= 1'b0;
            monitor_output_oe_o <= 1'b0;
        end else begin
            monitor_output_oe_o <= mon_sel_ff != MON_TRISTATE;
            case (mon_sel_ff)
                MON_HIGH: monitor_output_o <= 1'b1;
                MON_REF_DIV: monitor_output_o <= ref_pulse_o;
                MON_FB_DIV: monitor_output_o <= fb_pulse_o;
                MON_SDATA: monitor_output_o <= serial_data_i;
                default: monitor_output_o <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence wr_mod_s;
        wr2;
    endsequence
    sequence wr_int_s;
        wr0;
    endsequence

    int_field_a: assert property (wr0 |=> int_value_o == $past(ser.word[26:15]))
        else $error("integer value not taken from bits 26:15");
    mon_field_a: assert property (wr0 |=> mon_sel_ff == $past(ser.word[30:27]))
        else $error("monitor select not taken from bits 30:27");
    mod_held_a: assert property (wr_mod_s ##1 !wr0 |=> $stable(fraction_modulus_o))
        else $error("modulus changed without integer word write");
    mod_apply_a: assert property (wr_int_s |=>
        fraction_modulus_o == $past(pend_mod_ff))
        else $error("pending modulus not applied on integer word write");
    phase_field_a: assert property (wr1 |=> pend_phase_ff == $past(ser.word[14:3]))
        else $error("phase value not taken from bits 14:3");
    bad_sel_a: assert property (ser.load && sel > 3'h4 |=>
        $stable(int_value_o) && $stable(pend_mod_ff) && $stable(pd_polarity_o))
        else $error("unused select code changed a latch");
    pump_off_a: assert property (!chip_enable_i |=> pump_three_state_o && power_down_o)
        else $error("charge pump not three-stated with chip enable low");
    ref_total_a: assert property (##1 ref_div_total_o ==
        ($past(reference_halving_bit_o) ? 7'(2 * $past(r_ratio)) : 7'($past(r_ratio))))
        else $error("reference divide total wrong");
    ldp_field_a: assert property (wr3 |=> lock_detect_precision_o == $past(ser.word[7]))
        else $error("lock detect precision not from bit 7");

endmodule // twscl_latches

// *** shared/twscl_pkg.sv ***
// twscl_pkg: field layout, select codes and reset values of the serial
// configuration latches. assumes 32-bit words shifted msb first.
package twscl_pkg;

    localparam int WORD_W = 32;
    localparam int SEL_W = 3;

    // latch select codes in bits 2:0
    typedef enum logic [2:0] {
        TWSCL_SEL_INT_FRAC = 3'h0,
        TWSCL_SEL_PHASE = 3'h1,
        TWSCL_SEL_MOD_REF = 3'h2,
        TWSCL_SEL_FUNC = 3'h3,
        TWSCL_SEL_CLKDIV = 3'h4
    } twscl_sel_e;

    // integer/fraction word
    localparam int MON_MSB = 30;
    localparam int MON_LSB = 27;
    localparam int INT_MSB = 26;
    localparam int INT_LSB = 15;
    localparam int FRAC_MSB = 14;
    localparam int FRAC_LSB = 3;
    // output phase word
    localparam int PHASE_MSB = 14;
    localparam int PHASE_LSB = 3;
    // modulus/reference word
    localparam int NOISE_MSB = 30;
    localparam int NOISE_LSB = 29;
    localparam int CSR_BIT = 28;
    localparam int CUR_MSB = 27;
    localparam int CUR_LSB = 24;
    localparam int PRESC_BIT = 22;
    localparam int HALF_BIT = 21;
    localparam int DBL_BIT = 20;
    localparam int RCNT_MSB = 19;
    localparam int RCNT_LSB = 15;
    localparam int MOD_MSB = 14;
    localparam int MOD_LSB = 3;
    // function control word
    localparam int SDRST_BIT = 14;
    localparam int LDP_BIT = 7;
    localparam int PDPOL_BIT = 6;
    localparam int PWRDN_BIT = 5;
    localparam int CP3S_BIT = 4;
    localparam int CNTRST_BIT = 3;

    // values after reset
    localparam logic [11:0] INT_RST = 12'h017;
    localparam logic [11:0] MOD_RST = 12'h002;
    localparam logic [4:0] RCNT_RST = 5'h01;

    // monitor select codes
    localparam logic [3:0] MON_TRISTATE = 4'h0;
    localparam logic [3:0] MON_HIGH = 4'h1;
    localparam logic [3:0] MON_LOW = 4'h2;
    localparam logic [3:0] MON_REF_DIV = 4'h3;
    localparam logic [3:0] MON_FB_DIV = 4'h4;
    localparam logic [3:0] MON_SDATA = 4'h7;

endpackage

// *** shared/twscl_serial_if.sv ***
// twscl_serial_if: shifted word and load pulse from the serial front end
// to the latch bank. one clock domain, core_clk_i.
`timescale 1ns/10ps
interface twscl_serial_if;
    logic [31:0] word;
    logic load;
    modport shifter (output word, output load);
    modport bank (input word, input load);
endinterface

// *** hw/twscl_shifter.sv ***
// twscl_shifter: 32-bit input shift register and load strobe edge detect.
// assumes serial pins already synchronous to core_clk_i.
`timescale 1ns/10ps
module twscl_shifter
    import twscl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic load_strobe_i,
    twscl_serial_if.shifter ser
);

    logic sclk_ff;
    logic strobe_ff;
    logic [WORD_W-1:0] word_ff;
    logic load_ff;

    assign ser.word = word_ff;
    assign ser.load = load_ff;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sclk_ff <= 1'b0;
            strobe_ff <= 1'b0;
        end else begin
            sclk_ff <= serial_clk_i;
            strobe_ff <= load_strobe_i;
        end
    end

    // first bit in ends up at the top: msb first
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            word_ff <= 32'h0;
        end else if (serial_clk_i && !sclk_ff) begin
            word_ff <= {word_ff[WORD_W-2:0], serial_data_i};
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            load_ff <= 1'b0;
        end else begin
            load_ff <= load_strobe_i && !strobe_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    shift_in_a: assert property (
        serial_clk_i && !sclk_ff |=> word_ff == {$past(word_ff[30:0]), $past(serial_data_i)})
        else $error("shift register did not take the data bit");
    load_edge_a: assert property (
        load_strobe_i && !strobe_ff |=> load_ff ##1 !load_ff)
        else $error("load pulse not one cycle after strobe rise");

endmodule // twscl_shifter

// *** test/twscl_host_model.sv ***
// twscl_host_model: host side of the three-wire serial port.
// assumes the pins are sampled on core_clk_i rising edges.
`timescale 1ns/10ps
module twscl_host_model (
    input wire logic core_clk_i,
    output logic serial_clk_o,
    output logic serial_data_o,
    output logic load_strobe_o
);
    initial begin
        serial_clk_o = 1'b0;
        serial_data_o = 1'b0;
        load_strobe_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // one word per call; slow stretches each serial clock phase
    task automatic send_word(input logic [31:0] w, input int slow);
        for (int i = 31; i >= 0; i--) begin
            @(posedge core_clk_i);
            serial_clk_o <= 1'b0;
            serial_data_o <= w[i]; // msb first, select bits last
            repeat (slow) @(posedge core_clk_i);
            @(posedge core_clk_i);
            serial_clk_o <= 1'b1; // one bit per rise
            repeat (slow) @(posedge core_clk_i);
        end
        @(posedge core_clk_i);
        serial_clk_o <= 1'b0;
        // line driven to the inverse of the last bit sent
        serial_data_o <= ~w[0];
        @(posedge core_clk_i);
        load_strobe_o <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        load_strobe_o <= 1'b0;
        // strobe stays low long enough for back to back words
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask
endmodule // twscl_host_model

// *** test/tb.sv ***
// tb: self-checking bench for the serial configuration latches.
// assumes twscl_pkg compiled first; host model drives the serial pins.
`timescale 1ns/10ps
module tb;
    logic core_clk_i, rst_n_i, chip_enable_i, ref_tick_i, rf_tick_i;
    logic sclk, sdata, lstrobe, mon, mon_oe, p3s, pdn, dbl, half, cycle_slip_reduction, presc, pol, lock_detect_precision;
    logic [11:0] intv, fracv, modv, phase;
    logic [4:0] rcnt;
    logic [3:0] cur;
    logic [1:0] noise;
    logic [6:0] rtot;
    logic rpulse, fpulse;
    int err_count = 0;
    int n_tests = 0;

    twscl_host_model host_i (.core_clk_i(core_clk_i), .serial_clk_o(sclk),
        .serial_data_o(sdata), .load_strobe_o(lstrobe));
    twscl_latches twscl_latches_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .serial_clk_i(sclk), .serial_data_i(sdata), .load_strobe_i(lstrobe),
        .chip_enable_i(chip_enable_i), .ref_tick_i(ref_tick_i), .rf_tick_i(rf_tick_i),
        .monitor_output_o(mon), .monitor_output_oe_o(mon_oe), .pump_three_state_o(p3s),
        .power_down_o(pdn), .int_value_o(intv), .frac_value_o(fracv),
        .fraction_modulus_o(modv), .phase_value_o(phase), .ref_count_o(rcnt),
        .ref_doubler_o(dbl), .reference_halving_bit_o(half), .pump_current_o(cur),
        .noise_mode_o(noise), .cycle_slip_reduction_o(cycle_slip_reduction), .prescaler_o(presc),
        .pd_polarity_o(pol), .lock_detect_precision_o(lock_detect_precision), .ref_div_total_o(rtot),
        .ref_pulse_o(rpulse), .fb_pulse_o(fpulse));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [31:0] w);
        host_i.send_word(w, 0);
    endtask

    function automatic logic [31:0] w0(input logic [3:0] m, input logic [11:0] n,
                                       input logic [11:0] f);
        return {1'b0, m, n, f, 3'h0};
    endfunction
    ////////////////////////////////////////////////////////////////
    task automatic t_dbuf();
        wr({1'b0, 2'h2, 1'b1, 4'hA, 1'b0, 1'b1, 1'b1, 1'b1, 5'h05, 12'hFFF, 3'h2});
        chk("noise", 32'h2, 32'(noise));
        chk("csr", 32'h1, 32'(cycle_slip_reduction));
        chk("presc", 32'h1, 32'(presc));
        chk("mod held", 32'h002, 32'(modv));
        chk("r held", 32'h01, 32'(rcnt));
        chk("cur held", 32'h0, 32'(cur));
        chk("half held", 32'h0, 32'(half));
        wr({17'h0, 12'h123, 3'h1});
        chk("phase held", 32'h0, 32'(phase));
        wr(w0(4'h0, 12'hFFF, 12'hFFE)); // follow-up word applies them
        chk("mod", 32'hFFF, 32'(modv));
        chk("phase", 32'h123, 32'(phase));
        chk("r", 32'h05, 32'(rcnt));
        chk("dbl", 32'h1, 32'(dbl));
        chk("half", 32'h1, 32'(half));
        chk("cur", 32'hA, 32'(cur));
        chk("int", 32'hFFF, 32'(intv));
        chk("frac", 32'hFFE, 32'(fracv));
        chk("r total", 32'd10, 32'(rtot));
        $display("test dbuf done");
    endtask

    task automatic t_ignore();
        for (int s = 4; s < 8; s++) begin
            wr({1'b0, 4'h1, 12'h017, 12'h001, 3'(s)});
            chk("int kept", 32'hFFF, 32'(intv));
            chk("mon oe kept", 32'h0, 32'(mon_oe));
        end
        $display("test ignore done");
    endtask

    task automatic t_func();
        host_i.send_word({17'h0, 1'b0, 6'h0, 5'b11010, 3'h3}, 2);
        chk("ldp", 32'h1, 32'(lock_detect_precision));
        chk("pol", 32'h1, 32'(pol));
        chk("3state", 32'h1, 32'(p3s));
        chk("pdn off", 32'h0, 32'(pdn));
        host_i.send_word({17'h0, 1'b0, 6'h0, 5'b00100, 3'h3}, 2);
        chk("pdn on", 32'h1, 32'(pdn));
        wr({32'h0000_0003});
        chk("pdn clr", 32'h0, 32'(pdn));
        chk("3state clr", 32'h0, 32'(p3s));
        $display("test func done");
    endtask

    task automatic t_enable();
        @(posedge core_clk_i);
        chip_enable_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        chip_enable_i <= 1'b1;
        #1;
        chk("ce pdn", 32'h1, 32'(pdn));
        chk("ce 3state", 32'h1, 32'(p3s));
        repeat (3) @(posedge core_clk_i);
        #1;
        chk("ce pdn off", 32'h0, 32'(pdn));
        $display("test enable done");
    endtask

    task automatic t_monitor();
        for (int c = 0; c < 4; c++) begin
            wr(w0(4'((c == 3) ? 7 : c), 12'h017, 12'h000));
            chk("mon oe", 32'(c != 0), 32'(mon_oe));
            // code 7 echoes the data line, released high after a word ending in 000
            if (c != 0) chk("mon val", 32'(c != 2), 32'(mon));
        end
        $display("test monitor done");
    endtask

    task automatic t_count();
        int rl, rp, fl, fp, nr, nm;
        rl = 0; rp = 0; fl = 0; fp = 0; nr = 0; nm = 0;
        wr({1'b0, 2'h0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h03, 12'hFFF, 3'h2});
        wr(w0(4'h3, 12'h017, 12'h000));
        for (int i = 1; i <= 100; i++) begin
            for (int k = 0; k < 3; k++) begin
                @(posedge core_clk_i);
                ref_tick_i <= (k == 0);
                rf_tick_i <= (k == 0);
                #1;
                if (rpulse === 1'b1) begin
                    rp = rl; rl = i; nr++;
                end
                if (fpulse === 1'b1) begin
                    fp = fl; fl = i;
                end
                if (mon === 1'b1) nm++;
            end
        end
        chk("ref period", 32'd3, 32'(rl - rp));
        chk("fb period", 32'd23, 32'(fl - fp));
        chk("ref pulses", 32'd33, 32'(nr));
        chk("mon pulses", 32'd33, 32'(nm));
        // counter reset bit must hold the reference divider quiet
        wr(32'h0000_000B);
        nr = 0;
        for (int i = 0; i < 30; i++) begin
            @(posedge core_clk_i);
            ref_tick_i <= 1'b1;
            #1;
            if (rpulse !== 1'b0) nr++;
        end
        @(posedge core_clk_i);
        ref_tick_i <= 1'b0;
        chk("held pulses", 32'd0, 32'(nr));
        $display("test count done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        rst_n_i = 1'b0;
        chip_enable_i = 1'b1;
        ref_tick_i = 1'b0;
        rf_tick_i = 1'b0;
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk("rst int", 32'h017, 32'(intv));
        chk("rst mod", 32'h002, 32'(modv));
        chk("rst r", 32'h01, 32'(rcnt));
        chk("rst pdn", 32'h1, 32'(pdn));
        chk("rst oe", 32'h0, 32'(mon_oe));
        repeat (2) @(posedge core_clk_i);
        t_dbuf();
        t_ignore();
        t_func();
        t_enable();
        t_monitor();
        t_count();
        end_sim();
    end

    initial begin
        repeat (50000) @(posedge core_clk_i);
        err_count++;
        $display("ERROR watchdog expected finish seen hang");
        end_sim();
    end
endmodule // tb
